// ### inc/drpf_cfg.svh
// constants of the daily redundant payload framer: register map, field codes, reset values
// assumes one 32-bit AHB-Lite slave port and a meter source on the same clock
`ifndef DRPF_CFG_SVH
`define DRPF_CFG_SVH

// register word offsets (byte addresses)
`define DRPF_OFF_CTRL 8'h00
`define DRPF_OFF_IVAL 8'h04
`define DRPF_OFF_STAT 8'h08
`define DRPF_OFF_FRMS 8'h0c
`define DRPF_OFF_MIDE 8'h10
`define DRPF_OFF_SEED 8'h14

// control register fields
`define DRPF_CTRL_EN 0
`define DRPF_CTRL_UNIT_LSB 4
`define DRPF_CTRL_VSC_LSB 8

// reset values
`define DRPF_RST_UNIT 4'h3
`define DRPF_RST_VSC 3'h3
`define DRPF_RST_IVH 5'h01
`define DRPF_RST_IVM 11'h03c
`define DRPF_RST_LFSR 16'hace1

// unit selector codes above the plain Wh scales
`define DRPF_UNIT_MJ 4'h8
`define DRPF_UNIT_MCAL 4'ha
`define DRPF_UNIT_MAX 4'hc

// payload codes
`define DRPF_FMT_ID 8'h18
`define DRPF_DIF_CUR 8'h04
`define DRPF_DIF_STO 8'h44
`define DRPF_DIF_STO_ERR 8'h74
`define DRPF_VIF_EXT 8'hfb
`define DRPF_VIF_VOL 5'h02
`define DRPF_DIF_ID 8'h0c
`define DRPF_VIF_ID 8'h78
`define DRPF_VIF_INFO0 8'hfd
`define DRPF_VIF_INFO1 8'h17
`define DRPF_VIF_DATE 8'h6d

// timing: longest random uplink delay in minutes
`define DRPF_MAX_DLY_MIN 15

`endif

// ### inc/drpf_pkg.sv
// types of the daily redundant payload framer
// assumes drpf_cfg.svh is compiled alongside
package drpf_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_SEND = 3'b100
	} drpf_state_e;

	typedef struct packed {
		drpf_state_e st;
		logic en;
		logic [3:0] unit;
		logic [2:0] vsc;
		logic [4:0] iv_hours;
		logic [10:0] iv_min;
		logic [15:0] lfsr;
		logic [3:0] dly;
		logic [5:0] idx;
		logic [3:0] f_unit;
		logic [2:0] f_vsc;
		logic [31:0] s_energy;
		logic [31:0] s_volume;
		logic [31:0] s_id;
		logic [31:0] s_info;
		logic [31:0] s_date;
		logic [31:0] s_mid;
		logic s_mid_ok;
		logic [31:0] mid_energy;
		logic mid_ok;
		logic [15:0] frames;
	} drpf_state_s;

endpackage

// ### design/drpf_skid.sv
// two-entry buffer between the byte generator and the radio transmitter
// assumes both sides on hclk; a stall downstream backs up into the generator
`timescale 1ns/1ps
`default_nettype none

module drpf_skid #(
	parameter int W = 9
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);

	typedef struct packed {
		logic [1:0][W-1:0] mem;
		logic [1:0] cnt;
		logic rd;
		logic wr;
	} drpf_skid_s;

	drpf_skid_s q, d;
	logic push, pop;

	// ready only counts free entries, so a full buffer never drops a word
	assign in_ready = (q.cnt != 2'd2);
	assign out_valid = (q.cnt != 2'd0);
	assign out_data = q.mem[q.rd];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// next state of pointers and storage
	always_comb begin
		d = q;
		if (push) begin
			d.mem[q.wr] = in_data;
			d.wr = ~q.wr;
		end
		if (pop) begin
			d.rd = ~q.rd;
		end
		d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

// ### design/drpf_ahb.sv
// AHB-Lite slave front end: zero wait states, always OKAY
// assumes the owner supplies the read word for the address-phase index
`timescale 1ns/1ps
`default_nettype none

module drpf_ahb (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	input wire logic [31:0] rd_word,
	output logic [7:0] rd_addr,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic wr_en,
	output logic [7:0] wr_addr,
	output logic [31:0] wr_data
);

	typedef struct packed {
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
	} drpf_ahb_s;

	drpf_ahb_s q, d;
	logic take;

	// only whole-word transfers exist on this port; hsize is not decoded
	assign take = hsel && htrans[1] && hready;
	assign rd_addr = {haddr[7:2], 2'b00};
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign wr_en = q.wr_pend;
	assign wr_addr = q.wr_addr;
	assign wr_data = hwdata;

	// read data is sampled in the address phase; high address bits alias
	always_comb begin
		d = q;
		d.wr_pend = take && hwrite;
		if (take) begin
			d.wr_addr = rd_addr;
			d.rdata = hwrite ? 32'h0000_0000 : rd_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

`default_nettype wire

// ### design/drpf_framer.sv
// daily redundant payload framer: schedules, snapshots and serialises format 0x18
// assumes meter inputs and hour/minute ticks come from logic on hclk
//
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "drpf_cfg.svh"

module drpf_framer (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic [31:0] heat_energy_total,
	input wire logic [31:0] meter_volume,
	input wire logic [31:0] meter_ident,
	input wire logic [31:0] meter_info,
	input wire logic [6:0] meter_year,
	input wire logic [3:0] meter_month,
	input wire logic [4:0] meter_day,
	input wire logic [4:0] meter_hour,
	input wire logic [5:0] meter_minute,
	input wire logic meter_dst,
	input wire logic meter_time_ok,
	input wire logic hour_tick,
	input wire logic minute_tick,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] tx_data,
	output logic tx_last
);

	drpf_pkg::drpf_state_s q, d;
	logic [7:0] rd_addr, wr_addr;
	logic [31:0] rd_word, wr_data;
	logic wr_en;
	logic push, push_last, push_ready;
	logic [7:0] push_data;
	logic ext, due, midnight, take;
	logic [5:0] len_e, off_vol, off_id, off_info, off_dt, off_mid, last_idx;
	logic [7:0] vif_e, dif_mid;
	logic [55:0] fld_e, fld_mid, fld_info;
	logic [47:0] fld_vol, fld_id, fld_dt;
	logic [4:0] ivh_new;
	logic [31:0] date_word;

	// legal transmit intervals in minutes mapped to hours; zero means refused
	function automatic logic [4:0] ival_hours(input logic [10:0] m);
		case (m)
			11'd60: ival_hours = 5'd1;
			11'd120: ival_hours = 5'd2;
			11'd180: ival_hours = 5'd3;
			11'd240: ival_hours = 5'd4;
			11'd360: ival_hours = 5'd6;
			11'd480: ival_hours = 5'd8;
			11'd720: ival_hours = 5'd12;
			11'd1440: ival_hours = 5'd24;
			default: ival_hours = 5'd0;
		endcase
	endfunction

	// unit selector to value-information code
	function automatic logic [7:0] unit_vif(input logic [3:0] u);
		case (u)
			4'h8: unit_vif = 8'h0e;
			4'h9: unit_vif = 8'h0f;
			4'ha: unit_vif = 8'h0d;
			4'hb: unit_vif = 8'h0e;
			4'hc: unit_vif = 8'h0f;
			default: unit_vif = {5'h00, u[2:0]};
		endcase
	endfunction

	drpf_ahb u_ahb (
		.hclk(hclk),
		.hresetn(hresetn),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.hwdata(hwdata),
		.rd_word(rd_word),
		.rd_addr(rd_addr),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data)
	);

	drpf_skid #(
		.W(9)
	) u_skid (
		.hclk(hclk),
		.hresetn(hresetn),
		.in_valid(push),
		.in_ready(push_ready),
		.in_data({push_last, push_data}),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data({tx_last, tx_data})
	);

	// register read mux; unmapped words read zero
	always_comb begin
		case (rd_addr)
			`DRPF_OFF_CTRL: rd_word = {21'h0, q.vsc, q.unit, 3'h0, q.en};
			`DRPF_OFF_IVAL: rd_word = {21'h0, q.iv_min};
			`DRPF_OFF_STAT: rd_word = {29'h0, q.st == drpf_pkg::ST_SEND,
				q.st == drpf_pkg::ST_WAIT, q.mid_ok};
			`DRPF_OFF_FRMS: rd_word = {16'h0, q.frames};
			`DRPF_OFF_MIDE: rd_word = q.mid_energy;
			`DRPF_OFF_SEED: rd_word = {16'h0, q.lfsr};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// packed date/time word: year split high/low, dst, error, reserved zero
	assign date_word = {meter_year[6:3], meter_month, meter_year[2:0], meter_day,
		meter_dst, 2'b00, meter_hour,
		~meter_time_ok, 1'b0, meter_minute};

	// scheduling terms: readout on the hour, midnight is hour zero
	assign midnight = hour_tick && (meter_hour == 5'd0);
	assign due = (q.iv_hours != 5'd0) && ((meter_hour % q.iv_hours) == 5'd0);
	assign take = hour_tick && due && q.en && (q.st == drpf_pkg::ST_IDLE);
	// a write with any bit above the minute field set is refused, not aliased
	assign ivh_new = (wr_data[31:11] == 21'h0) ? ival_hours(wr_data[10:0]) : 5'd0;

	// field images, byte 0 in the low bits so values go out low byte first
	assign ext = (q.f_unit >= `DRPF_UNIT_MCAL);
	assign vif_e = unit_vif(q.f_unit);
	assign dif_mid = q.s_mid_ok ? `DRPF_DIF_STO : `DRPF_DIF_STO_ERR;
	assign fld_e = ext ? {q.s_energy, vif_e, `DRPF_VIF_EXT, `DRPF_DIF_CUR}
		: {8'h00, q.s_energy, vif_e, `DRPF_DIF_CUR};
	assign fld_mid = ext ? {q.s_mid, vif_e, `DRPF_VIF_EXT, dif_mid}
		: {8'h00, q.s_mid, vif_e, dif_mid};
	assign fld_vol = {q.s_volume, `DRPF_VIF_VOL, q.f_vsc, `DRPF_DIF_CUR};
	assign fld_id = {q.s_id, `DRPF_VIF_ID, `DRPF_DIF_ID};
	assign fld_info = {q.s_info, `DRPF_VIF_INFO1, `DRPF_VIF_INFO0, `DRPF_DIF_CUR};
	assign fld_dt = {q.s_date, `DRPF_VIF_DATE, `DRPF_DIF_CUR};

	// field start offsets follow the fixed order
	assign len_e = ext ? 6'd7 : 6'd6;
	assign off_vol = 6'd1 + len_e;
	assign off_id = off_vol + 6'd6;
	assign off_info = off_id + 6'd6;
	assign off_dt = off_info + 6'd7;
	assign off_mid = off_dt + 6'd6;
	assign last_idx = off_mid + len_e - 6'd1;

	// byte generator feeding the buffer; stalls while the buffer is full
	always_comb begin
		logic [5:0] k;
		k = 6'd0;
		push = (q.st == drpf_pkg::ST_SEND);
		push_last = (q.idx == last_idx);
		if (q.idx == 6'd0) begin
			push_data = `DRPF_FMT_ID;
		end else if (q.idx < off_vol) begin
			k = q.idx - 6'd1;
			push_data = fld_e[{k[2:0], 3'b000} +: 8];
		end else if (q.idx < off_id) begin
			k = q.idx - off_vol;
			push_data = fld_vol[{k[2:0], 3'b000} +: 8];
		end else if (q.idx < off_info) begin
			k = q.idx - off_id;
			push_data = fld_id[{k[2:0], 3'b000} +: 8];
		end else if (q.idx < off_dt) begin
			k = q.idx - off_info;
			push_data = fld_info[{k[2:0], 3'b000} +: 8];
		end else if (q.idx < off_mid) begin
			k = q.idx - off_dt;
			push_data = fld_dt[{k[2:0], 3'b000} +: 8];
		end else begin
			k = q.idx - off_mid;
			push_data = fld_mid[{k[2:0], 3'b000} +: 8];
		end
	end

	// next state: registers, midnight latch, schedule and serialiser
	always_comb begin
		d = q;
		d.lfsr = {q.lfsr[14:0], q.lfsr[15] ^ q.lfsr[13] ^ q.lfsr[12] ^ q.lfsr[10]};
		if (wr_en) begin
			case (wr_addr)
				`DRPF_OFF_CTRL: begin
					d.en = wr_data[`DRPF_CTRL_EN];
					// unknown unit or volume codes keep the old setting
					if (wr_data[`DRPF_CTRL_UNIT_LSB +: 4] <= `DRPF_UNIT_MAX) begin
						d.unit = wr_data[`DRPF_CTRL_UNIT_LSB +: 4];
					end
					if (wr_data[`DRPF_CTRL_VSC_LSB +: 3] != 3'd0) begin
						d.vsc = wr_data[`DRPF_CTRL_VSC_LSB +: 3];
					end
				end
				`DRPF_OFF_IVAL: begin
					if (ivh_new != 5'd0) begin
						d.iv_hours = ivh_new;
						d.iv_min = wr_data[10:0];
					end
				end
				`DRPF_OFF_SEED: begin
					// an all-zero seed would lock the generator
					if (wr_data[15:0] != 16'h0000) begin
						d.lfsr = wr_data[15:0];
					end
				end
				default: begin
				end
			endcase
		end
		// latched once per day and held until the next midnight
		if (midnight) begin
			d.mid_energy = heat_energy_total;
			d.mid_ok = 1'b1;
		end
		case (q.st)
			drpf_pkg::ST_IDLE: begin
				if (take) begin
					d.s_energy = heat_energy_total;
					d.s_volume = meter_volume;
					d.s_id = meter_ident;
					d.s_info = meter_info;
					d.s_date = date_word;
					d.s_mid = midnight ? heat_energy_total : q.mid_energy;
					d.s_mid_ok = midnight || q.mid_ok;
					d.f_unit = q.unit;
					d.f_vsc = q.vsc;
					d.dly = q.lfsr[3:0];
					d.st = drpf_pkg::ST_WAIT;
				end
			end
			drpf_pkg::ST_WAIT: begin
				if (q.dly == 4'd0) begin
					d.idx = 6'd0;
					d.st = drpf_pkg::ST_SEND;
				end else if (minute_tick) begin
					d.dly = q.dly - 4'd1;
				end
			end
			drpf_pkg::ST_SEND: begin
				if (push_ready) begin
					d.idx = q.idx + 6'd1;
					if (push_last) begin
						d.frames = q.frames + 16'd1;
						d.st = drpf_pkg::ST_IDLE;
					end
				end
			end
			default: begin
				d.st = drpf_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.st <= drpf_pkg::ST_IDLE;
			q.unit <= `DRPF_RST_UNIT;
			q.vsc <= `DRPF_RST_VSC;
			q.iv_hours <= `DRPF_RST_IVH;
			q.iv_min <= `DRPF_RST_IVM;
			q.lfsr <= `DRPF_RST_LFSR;
		end else begin
			q <= d;
		end
	end

	// checks next to the logic they guard
	logic pushed;
	assign pushed = push && push_ready;

	a_fmt_first: assert property (@(posedge hclk) disable iff (!hresetn)
		pushed && q.idx == 6'd0 |-> push_data == 8'h18)
		else $error("first payload byte is not the format identifier");

	a_mid_hold: assert property (@(posedge hclk) disable iff (!hresetn)
		!(hour_tick && meter_hour == 5'd0) |=> $stable(q.mid_energy))
		else $error("midnight value changed outside midnight");

	a_ival_legal: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_en && wr_addr == 8'h04
		&& (wr_data[31:11] != 21'h0 || ival_hours(wr_data[10:0]) == 5'd0)
		|=> $stable(q.iv_min))
		else $error("illegal transmit interval was accepted");

	a_date_pack: assert property (@(posedge hclk) disable iff (!hresetn)
		take |=> {q.s_date[31:28], q.s_date[23:21]} == $past(meter_year)
		&& q.s_date[12:8] == $past(meter_hour) && q.s_date[15] == $past(meter_dst))
		else $error("date word year, hour or dst misplaced");

	a_date_flags: assert property (@(posedge hclk) disable iff (!hresetn)
		take |=> q.s_date[7] == !$past(meter_time_ok) && q.s_date[6] == 1'b0)
		else $error("timestamp error or reserved bit wrong");

	a_mid_dif: assert property (@(posedge hclk) disable iff (!hresetn)
		pushed && q.idx == off_mid && !q.s_mid_ok |-> push_data == 8'h74)
		else $error("invalid midnight value not marked as error state");

	a_frame_len: assert property (@(posedge hclk) disable iff (!hresetn)
		pushed && push_last |-> q.idx == (ext ? 6'd39 : 6'd37))
		else $error("payload length does not match the field layout");

	a_lsb_first: assert property (@(posedge hclk) disable iff (!hresetn)
		pushed && q.idx == off_vol + 6'd2 |-> push_data == q.s_volume[7:0])
		else $error("volume value not sent low byte first");

	a_delay_end: assert property (@(posedge hclk) disable iff (!hresetn)
		q.st == drpf_pkg::ST_WAIT && q.dly == 4'd0 |=> q.st == drpf_pkg::ST_SEND)
		else $error("uplink delay overran");

	a_read_hour: assert property (@(posedge hclk) disable iff (!hresetn)
		$rose(q.st == drpf_pkg::ST_WAIT) |-> $past(hour_tick))
		else $error("readout started off the hour");

	c_ext_frame: cover property (@(posedge hclk) disable iff (!hresetn)
		pushed && push_last && ext);
	c_midnight: cover property (@(posedge hclk) disable iff (!hresetn)
		take && meter_hour == 5'd0);
	c_stall: cover property (@(posedge hclk) disable iff (!hresetn)
		push && !push_ready);

endmodule

`default_nettype wire

// ### dv/drpf_uplink_model.sv
// uplink model: a radio transmitter that takes payload bytes and may stall at any cycle
// assumes bytes arrive on hclk by valid/ready; the bench drives the stall pattern
`timescale 1ns/1ps
`default_nettype none

module drpf_uplink_model (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_last,
	input wire logic accept
);
	logic [7:0] got[$];
	int frames = 0;
	int last_at = 0;

	// ready follows the stall pattern; a real radio also pauses in mid-frame
	assign tx_ready = accept & hresetn;

	// record each accepted byte; the flagged last byte closes a frame
	always @(posedge hclk) begin
		if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
			got.push_back(tx_data);
			if (tx_last === 1'b1) begin
				last_at = got.size();
				frames++;
			end
		end
	end
endmodule

`default_nettype wire

// ### dv/test_daily_redundant_payload_framer.sv
// self-checking bench of the payload framer: registers, whole frames, midnight latch
// assumes one AHB-Lite master here and the uplink model as the byte sink
`timescale 1ns/1ps
`default_nettype none
`include "drpf_cfg.svh"
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin miscompares++; \
	$display("FAIL %s expected %h seen %h", nm, ex, sn); end end

module test_daily_redundant_payload_framer;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0, hwrite = 1'b0, accept = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
	logic hreadyout, hresp, tx_valid, tx_ready, tx_last;
	logic [7:0] tx_data;
	logic [31:0] heat_energy_total = 32'h0, meter_volume = 32'h0;
	logic [31:0] meter_ident = 32'h0, meter_info = 32'h0, mid_e = 32'h0;
	logic [6:0] meter_year = 7'h0;
	logic [3:0] meter_month = 4'h1;
	logic [4:0] meter_day = 5'h1, meter_hour = 5'h1;
	logic [5:0] meter_minute = 6'h0;
	logic meter_dst = 1'b0, meter_time_ok = 1'b1, hour_tick = 1'b0, minute_tick = 1'b0;
	logic mid_ok = 1'b0;
	logic [1:0] mcnt = 2'h0;
	logic [7:0] exp_q[$];
	logic [31:0] ivs[8] = '{32'h78, 32'hb4, 32'hf0, 32'h168, 32'h1e0, 32'h2d0, 32'h5a0, 32'h3c};
	integer seed = 88;
	int miscompares = 0, checked = 0, cyc = 0, sent = 0;

	always #10 hclk = ~hclk;

	drpf_framer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.heat_energy_total(heat_energy_total), .meter_volume(meter_volume),
		.meter_ident(meter_ident), .meter_info(meter_info), .meter_year(meter_year),
		.meter_month(meter_month), .meter_day(meter_day), .meter_hour(meter_hour),
		.meter_minute(meter_minute), .meter_dst(meter_dst), .meter_time_ok(meter_time_ok),
		.hour_tick(hour_tick), .minute_tick(minute_tick), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last));

	drpf_uplink_model i_uplink (.hclk(hclk), .hresetn(hresetn), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_data(tx_data), .tx_last(tx_last), .accept(accept));

	// random stalls of the radio and a minute tick every fourth cycle to keep delays short
	always @(posedge hclk) begin
		accept <= ($random(seed) % 4) != 0;
		mcnt <= mcnt + 2'h1;
		minute_tick <= (mcnt == 2'h3);
	end

	// hang guard: the whole run needs a few thousand cycles
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up;
		end
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// single word transfer; each phase holds until hready is seen high at an edge
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		ahb(1'b0, a, 32'h0);
		`CHK(nm, ex, rd)
		`CHK("okay response", 1'b0, hresp)
	endtask

	// received word starting at byte index at, low byte first
	function automatic logic [31:0] got_w(input int at);
		return {i_uplink.got[at+3], i_uplink.got[at+2], i_uplink.got[at+1], i_uplink.got[at]};
	endfunction

	// expected bytes: prefix codes high byte first, data words low byte first
	function automatic void put_h(input logic [23:0] b, input int n);
		for (int k = n - 1; k >= 0; k--)
			exp_q.push_back(b[8*k +: 8]);
	endfunction
	function automatic void put_w(input logic [31:0] w);
		for (int k = 0; k < 4; k++)
			exp_q.push_back(w[8*k +: 8]);
	endfunction
	function automatic void put_e(input logic [7:0] dif, input logic [3:0] u);
		exp_q.push_back(dif);
		if (u >= 4'ha) begin
			put_h(24'h0000fb, 1);
			exp_q.push_back(8'h03 + {4'h0, u});
		end else begin
			exp_q.push_back(u >= 4'h8 ? 8'h06 + {4'h0, u} : {4'h0, u});
		end
	endfunction

	// one readout at the hour with random meter values; the energy input keeps moving after it
	task automatic frame(input logic [3:0] u, input logic [4:0] h);
		logic [2:0] vs;
		logic [31:0] dw;
		int n, md, ec, ln;
		vs = 3'h1 + 3'($unsigned($random(seed)) % 7);
		ec = (u >= 4'ha) ? 3 : 2;
		ahb(1'b1, `DRPF_OFF_CTRL, {21'h0, vs, u, 3'h0, 1'b1});
		i_uplink.got.delete();
		@(posedge hclk);
		heat_energy_total <= $random(seed);
		meter_volume <= $random(seed);
		meter_ident <= $random(seed);
		meter_info <= $random(seed);
		meter_year <= 7'($random(seed));
		meter_month <= 4'h1 + 4'($unsigned($random(seed)) % 12);
		meter_day <= 5'h1 + 5'($unsigned($random(seed)) % 28);
		meter_minute <= 6'($unsigned($random(seed)) % 60);
		meter_dst <= 1'($random(seed));
		meter_time_ok <= 1'($random(seed));
		meter_hour <= h;
		hour_tick <= 1'b1;
		@(posedge hclk);
		hour_tick <= 1'b0;
		if (h == 5'h0) begin
			mid_e = heat_energy_total;
			mid_ok = 1'b1;
		end
		dw = {meter_year[6:3], meter_month, meter_year[2:0], meter_day, meter_dst, 2'h0, h,
			~meter_time_ok, 1'b0, meter_minute};
		exp_q.delete();
		put_h(24'h000018, 1);
		put_e(8'h04, u);
		put_w(heat_energy_total);
		put_h({16'h0004, 5'h02, vs}, 2);
		put_w(meter_volume);
		put_h(24'h000c78, 2);
		put_w(meter_ident);
		put_h(24'h04fd17, 3);
		put_w(meter_info);
		put_h(24'h00046d, 2);
		put_w(dw);
		md = exp_q.size();
		put_e(mid_ok ? 8'h44 : 8'h74, u);
		put_w(mid_e);
		ln = exp_q.size();
		for (n = 0; n < 3000 && i_uplink.frames == sent; n++) begin
			@(posedge hclk);
			heat_energy_total <= $random(seed);
		end
		sent++;
		`CHK("frames seen", sent, i_uplink.frames)
		`CHK("frame length", ln, i_uplink.got.size())
		`CHK("last flag position", ln, i_uplink.last_at)
		for (n = 0; n < ln && n < i_uplink.got.size(); n++)
			`CHK("frame byte", exp_q[n], i_uplink.got[n])
		`CHK("format byte", 8'h18, i_uplink.got[0])
		`CHK("energy code", exp_q[ec], i_uplink.got[ec])
		`CHK("volume code", exp_q[ec + 6], i_uplink.got[ec + 6])
		`CHK("date word", dw, got_w(md - 4))
		`CHK("midnight dif", exp_q[md], i_uplink.got[md])
		`CHK("midnight value", mid_e, got_w(ln - 4))
		$display("test frame unit %0d hour %0d done", u, h);
	endtask

	// main sequence: reset, registers, a run of frames across two midnights, interval skip
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		rchk("control reset", `DRPF_OFF_CTRL, 32'h330);
		rchk("interval reset", `DRPF_OFF_IVAL, 32'h3c);
		rchk("status reset", `DRPF_OFF_STAT, 32'h0);
		rchk("unmapped read", 8'h20, 32'h0);
		ahb(1'b1, `DRPF_OFF_IVAL, 32'h64);
		rchk("refused interval", `DRPF_OFF_IVAL, 32'h3c);
		ahb(1'b1, `DRPF_OFF_IVAL, 32'h878);
		rchk("interval high bits", `DRPF_OFF_IVAL, 32'h3c);
		ahb(1'b1, `DRPF_OFF_CTRL, 32'hd0);
		rchk("refused unit", `DRPF_OFF_CTRL, 32'h330);
		foreach (ivs[k]) begin
			ahb(1'b1, `DRPF_OFF_IVAL, ivs[k]);
			rchk("interval", `DRPF_OFF_IVAL, ivs[k]);
		end
		$display("test registers done");
		for (int i = 0; i < 16; i++)
			frame(4'(i % 13), (i == 5 || i == 12) ? 5'h0 : 5'(i % 23 + 1));
		rchk("midnight energy", `DRPF_OFF_MIDE, mid_e);
		rchk("midnight valid", `DRPF_OFF_STAT, 32'h1);
		rchk("frames sent", `DRPF_OFF_FRMS, 32'(sent));
		ahb(1'b1, `DRPF_OFF_IVAL, 32'h78);
		@(posedge hclk);
		meter_hour <= 5'h3;
		hour_tick <= 1'b1;
		@(posedge hclk);
		hour_tick <= 1'b0;
		repeat (200) @(posedge hclk);
		`CHK("no readout off interval", sent, i_uplink.frames)
		frame(4'h3, 5'h4);
		$display("test interval done");
		wrap_up;
	end
endmodule

`default_nettype wire
